//--- pcit_core.sv
// pipelined byte-per-clock core sequencer with arithmetic datapath
`timescale 1ns/1ps
`default_nettype none
`include "pcit_consts.svh"
module pcit_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] code_data,
  input wire logic flash_read_timing_setting,
  output logic [15:0] code_addr,
  output logic [7:0] acc_value,
  output logic [7:0] b_value,
  output logic [7:0] program_status_word,
  output logic [15:0] data_pointer_register,
  output logic instr_done,
  output logic [3:0] instr_cycles,
  output logic unsupported_op
);
  import pcit_pkg::*;

  // period of the 20 MHz clock, well inside the 0 to 50 MHz range
  localparam int CLK_NS = `PCIT_CLK_PERIOD_NS;

  pcit_state_e state_reg, state_next; // sequencer position
  logic [15:0] pc_reg, pc_next; // fetch address
  logic [7:0] acc_reg, acc_next; // accumulator
  logic [7:0] b_reg, b_next; // multiply/divide partner
  logic [7:0] sw_reg, sw_next; // status word
  logic [15:0] dpr_reg, dpr_next; // data pointer
  logic [7:0] op_reg, op_next; // latched opcode
  logic [7:0] b1_reg, b1_next; // latched second byte
  logic [7:0] b2_reg, b2_next; // latched third byte
  logic [3:0] cnt_reg, cnt_next; // extra clocks left
  logic taken_reg, taken_next; // branch decided taken
  logic [15:0] tgt_reg, tgt_next; // branch destination
  logic [3:0] cyc_reg, cyc_next; // clocks spent in this instruction
  logic done_reg, done_next; // retire pulse
  logic [3:0] icyc_reg, icyc_next; // length of last instruction
  logic unk_reg, unk_next; // unknown opcode pulse
  logic [7:0] ram [0:255]; // internal data memory, not reset

  logic [7:0] cur_op, cur_b1, cur_b2; // bytes as seen this clock
  logic [3:0] hi, lo; // opcode nibbles
  logic [1:0] len; // instruction bytes
  logic last_byte, fin, taken, ind; // sequencing terms
  logic [3:0] extra; // clocks beyond the byte count
  logic [7:0] rn_addr, ri_addr, opnd_addr, opnd; // operand access
  logic [15:0] target, prod; // jump target and product
  pcit_alu_e alu_op; // arithmetic operation
  logic [7:0] alu_a, alu_b, alu_res; // arithmetic data
  logic alu_cy, alu_ac, alu_ov, alu_fwe; // arithmetic flags
  logic wr_en, wr_ind; // operand write-back
  logic [7:0] wr_addr, wr_val; // write-back target and data
  logic ram_we; // memory write strobe

  // byte count from the standard encoding
  function automatic logic [1:0] f_len(input logic [7:0] op);
    logic [3:0] h, l;
    h = op[7:4];
    l = op[3:0];
    f_len = 2'd1;
    if (op == `PCIT_OP_LJMP) f_len = 2'd3;
    else if (op == `PCIT_OP_JC || op == `PCIT_OP_JNC || op == `PCIT_OP_JZ ||
             op == `PCIT_OP_JNZ || op == `PCIT_OP_SJMP || op == `PCIT_OP_MOVAI) f_len = 2'd2;
    else if ((h == `PCIT_HI_ORL || h == `PCIT_HI_ANL || h == `PCIT_HI_XRL) && l == `PCIT_LO_DIRI) f_len = 2'd3;
    else if ((h == `PCIT_HI_ORL || h == `PCIT_HI_ANL || h == `PCIT_HI_XRL) && l == `PCIT_LO_DIRA) f_len = 2'd2;
    else if (f_acc_grp(op) && l == `PCIT_LO_IMM) f_len = 2'd2;
    // direct source: two bytes, two clocks
    else if ((f_acc_grp(op) || h == `PCIT_HI_INC || h == `PCIT_HI_DEC) && l == `PCIT_LO_DIR) f_len = 2'd2;
  endfunction

  // accumulator operation groups sharing one addressing layout
  function automatic logic f_acc_grp(input logic [7:0] op);
    f_acc_grp = (op[7:4] == `PCIT_HI_ADD || op[7:4] == `PCIT_HI_ADDC || op[7:4] == `PCIT_HI_SUBB ||
                 op[7:4] == `PCIT_HI_ORL || op[7:4] == `PCIT_HI_ANL || op[7:4] == `PCIT_HI_XRL) &&
                op[3:0] >= `PCIT_LO_IMM;
  endfunction

  // direct read: low half is memory, high half the special registers
  function automatic logic [7:0] f_rd(input logic [7:0] addr, input logic indirect);
    if (indirect || addr < `PCIT_SFR_BASE) f_rd = ram[addr];
    else if (addr == `PCIT_SFR_ACC) f_rd = acc_reg;
    else if (addr == `PCIT_SFR_B) f_rd = b_reg;
    else if (addr == `PCIT_SFR_SW) f_rd = sw_reg;
    else if (addr == `PCIT_SFR_DPL) f_rd = dpr_reg[7:0];
    else if (addr == `PCIT_SFR_DPH) f_rd = dpr_reg[15:8];
    else f_rd = 8'h00;
  endfunction

  pcit_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .cy_in(sw_reg[`PCIT_SW_CY]),
    .res(alu_res),
    .cy(alu_cy),
    .ac(alu_ac),
    .ov(alu_ov),
    .flags_we(alu_fwe)
  );

  // decode, timing and operand selection
  always_comb begin
    // bytes arrive one per clock; the current byte is used live
    cur_op = (state_reg == ST_OP) ? code_data : op_reg;
    cur_b1 = (state_reg == ST_B1) ? code_data : b1_reg;
    cur_b2 = (state_reg == ST_B2) ? code_data : b2_reg;
    hi = cur_op[7:4];
    lo = cur_op[3:0];
    len = f_len(cur_op);
    last_byte = (state_reg == ST_OP && len == 2'd1) || (state_reg == ST_B1 && len == 2'd2) ||
                (state_reg == ST_B2);
    // register bank selected by the two bank bits
    rn_addr = {3'b000, sw_reg[`PCIT_SW_RS1], sw_reg[`PCIT_SW_RS0], lo[2:0]};
    ri_addr = ram[{3'b000, sw_reg[`PCIT_SW_RS1], sw_reg[`PCIT_SW_RS0], 2'b00, lo[0]}];
    ind = (lo == `PCIT_LO_IND0 || lo == `PCIT_LO_IND1);
    opnd_addr = ind ? ri_addr : (lo >= `PCIT_LO_REG) ? rn_addr : cur_b1;
    opnd = f_rd(opnd_addr, ind || lo >= `PCIT_LO_REG);
    // branch condition from the live flags and accumulator
    case (cur_op)
      `PCIT_OP_JC: taken = sw_reg[`PCIT_SW_CY];
      `PCIT_OP_JNC: taken = !sw_reg[`PCIT_SW_CY];
      `PCIT_OP_JZ: taken = (acc_reg == 8'h00);
      `PCIT_OP_JNZ: taken = (acc_reg != 8'h00);
      `PCIT_OP_SJMP, `PCIT_OP_LJMP: taken = 1'b1;
      default: taken = 1'b0;
    endcase
    // relative offset counts from the byte after the instruction
    target = (cur_op == `PCIT_OP_LJMP) ? {cur_b1, code_data} : pc_reg + 16'h0001 + {{8{cur_b1[7]}}, cur_b1};
    // each opcode falls in one duration class; a branch's class depends on flash timing, a conditional branch's also on taken
    // multiply 1+3, divide 1+7, nothing past eight
    if (cur_op == `PCIT_OP_MUL) extra = `PCIT_EXTRA_MUL;
    else if (cur_op == `PCIT_OP_DIV) extra = `PCIT_EXTRA_DIV;
    // slow flash reads add a clock to a taken branch
    else if (taken) extra = `PCIT_EXTRA_TAKEN + {3'b000, flash_read_timing_setting};
    // indirect memory source costs one clock over its byte
    else if (ind && (f_acc_grp(cur_op) || hi == `PCIT_HI_INC || hi == `PCIT_HI_DEC)) extra = `PCIT_EXTRA_IND;
    // register forms have no extra clock
    else extra = `PCIT_CNT_RST;
    // retire on an exact clock count, no machine cycles
    fin = (last_byte && extra == `PCIT_CNT_RST) || (state_reg == ST_EX && cnt_reg == 4'h1);
  end

  // arithmetic operand and write-back selection
  always_comb begin
    alu_op = ALU_PASS;
    alu_a = acc_reg;
    alu_b = opnd;
    wr_en = 1'b0;
    wr_ind = 1'b0;
    wr_addr = opnd_addr;
    wr_val = alu_res;
    if (f_acc_grp(cur_op)) begin
      case (hi)
        `PCIT_HI_ADD: alu_op = ALU_ADD;
        `PCIT_HI_ADDC: alu_op = ALU_ADDC;
        `PCIT_HI_SUBB: alu_op = ALU_SUBB;
        `PCIT_HI_ORL: alu_op = ALU_OR;
        `PCIT_HI_ANL: alu_op = ALU_AND;
        default: alu_op = ALU_XOR;
      endcase
      if (lo == `PCIT_LO_IMM) alu_b = cur_b1;
    end else if ((hi == `PCIT_HI_ORL || hi == `PCIT_HI_ANL || hi == `PCIT_HI_XRL) &&
                 (lo == `PCIT_LO_DIRA || lo == `PCIT_LO_DIRI)) begin
      // logic into a direct byte, written back there
      alu_op = (hi == `PCIT_HI_ORL) ? ALU_OR : (hi == `PCIT_HI_ANL) ? ALU_AND : ALU_XOR;
      alu_a = f_rd(cur_b1, 1'b0);
      alu_b = (lo == `PCIT_LO_DIRA) ? acc_reg : cur_b2;
      wr_en = 1'b1;
      wr_addr = cur_b1;
    end else if ((hi == `PCIT_HI_INC || hi == `PCIT_HI_DEC) && lo >= `PCIT_LO_IMM) begin
      alu_op = (hi == `PCIT_HI_INC) ? ALU_INC : ALU_DEC;
      alu_a = (lo == `PCIT_LO_IMM) ? acc_reg : opnd;
      // register and indirect targets always land in memory
      wr_en = (lo != `PCIT_LO_IMM);
      wr_ind = ind || lo >= `PCIT_LO_REG;
    end
    // memory stays untouched while reset is held, whatever opcode sits at address zero
    ram_we = rst_n && fin && wr_en && (wr_ind || wr_addr < `PCIT_SFR_BASE);
  end

  // sequencer and architectural next state
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    acc_next = acc_reg;
    b_next = b_reg;
    sw_next = sw_reg;
    dpr_next = dpr_reg;
    op_next = cur_op;
    b1_next = cur_b1;
    b2_next = cur_b2;
    cnt_next = cnt_reg;
    taken_next = taken_reg;
    tgt_next = tgt_reg;
    cyc_next = cyc_reg + 4'h1;
    done_next = fin;
    icyc_next = icyc_reg;
    unk_next = 1'b0;
    prod = {8'h00, acc_reg} * {8'h00, b_reg};
    case (state_reg)
      ST_OP, ST_B1, ST_B2: begin
        // one program byte consumed per clock
        pc_next = pc_reg + 16'h0001;
        if (last_byte) begin
          taken_next = taken;
          tgt_next = target;
          cnt_next = extra;
          state_next = fin ? ST_OP : ST_EX;
        end else begin
          state_next = (state_reg == ST_OP) ? ST_B1 : ST_B2;
        end
      end
      ST_EX: begin
        cnt_next = cnt_reg - 4'h1;
        if (fin) begin
          state_next = ST_OP;
          // taken branch redirects after its last extra clock, one fast or two with slow flash
          if (taken_reg) pc_next = tgt_reg;
        end
      end
      default: state_next = ST_OP;
    endcase
    if (fin) begin
      cyc_next = `PCIT_CNT_RST;
      icyc_next = cyc_reg + 4'h1;
      if (alu_op != ALU_PASS && !wr_en) begin
        acc_next = alu_res;
        if (alu_fwe) begin
          sw_next[`PCIT_SW_CY] = alu_cy;
          sw_next[`PCIT_SW_AC] = alu_ac;
          sw_next[`PCIT_SW_OV] = alu_ov;
        end
      end else if (wr_en && !ram_we) begin
        // direct write into a special register
        case (wr_addr)
          `PCIT_SFR_ACC: acc_next = wr_val;
          `PCIT_SFR_B: b_next = wr_val;
          `PCIT_SFR_SW: sw_next = wr_val;
          `PCIT_SFR_DPL: dpr_next[7:0] = wr_val;
          `PCIT_SFR_DPH: dpr_next[15:8] = wr_val;
          default: sw_next = sw_reg;
        endcase
      end else if (!wr_en) begin
        case (cur_op)
          // sixteen bit increment, carry into the high byte
          `PCIT_OP_INCDP: dpr_next = dpr_reg + 16'h0001;
          // product split over accumulator and partner
          `PCIT_OP_MUL: begin
            acc_next = prod[7:0];
            b_next = prod[15:8];
            sw_next[`PCIT_SW_CY] = 1'b0;
            sw_next[`PCIT_SW_OV] = (prod[15:8] != 8'h00);
          end
          `PCIT_OP_DIV: begin
            // divide by zero raises overflow and clears carry, operands kept
            sw_next[`PCIT_SW_CY] = 1'b0;
            sw_next[`PCIT_SW_OV] = (b_reg == 8'h00);
            if (b_reg != 8'h00) begin
              acc_next = acc_reg / b_reg;
              b_next = acc_reg % b_reg;
            end
          end
          `PCIT_OP_MOVAI: acc_next = cur_b1;
          `PCIT_OP_CLRA: acc_next = 8'h00;
          `PCIT_OP_CPLA: acc_next = ~acc_reg;
          `PCIT_OP_NOP, `PCIT_OP_JC, `PCIT_OP_JNC, `PCIT_OP_JZ, `PCIT_OP_JNZ,
          `PCIT_OP_SJMP, `PCIT_OP_LJMP: acc_next = acc_reg;
          // forms this datapath lacks retire as one byte no-ops
          default: unk_next = 1'b1;
        endcase
      end
    end
    sw_next[`PCIT_SW_P] = ^acc_next;
  end

  // register every piece of state; memory has no reset
  always_ff @(posedge clk) begin
    if (ram_we) ram[wr_addr] <= wr_val;
    if (!rst_n) begin
      state_reg <= ST_OP;
      pc_reg <= `PCIT_PC_RST;
      acc_reg <= `PCIT_BYTE_RST;
      b_reg <= `PCIT_BYTE_RST;
      sw_reg <= `PCIT_BYTE_RST;
      dpr_reg <= `PCIT_WORD_RST;
      op_reg <= `PCIT_BYTE_RST;
      b1_reg <= `PCIT_BYTE_RST;
      b2_reg <= `PCIT_BYTE_RST;
      cnt_reg <= `PCIT_CNT_RST;
      taken_reg <= 1'b0;
      tgt_reg <= `PCIT_WORD_RST;
      cyc_reg <= `PCIT_CNT_RST;
      done_reg <= 1'b0;
      icyc_reg <= `PCIT_CNT_RST;
      unk_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      acc_reg <= acc_next;
      b_reg <= b_next;
      sw_reg <= sw_next;
      dpr_reg <= dpr_next;
      op_reg <= op_next;
      b1_reg <= b1_next;
      b2_reg <= b2_next;
      cnt_reg <= cnt_next;
      taken_reg <= taken_next;
      tgt_reg <= tgt_next;
      cyc_reg <= cyc_next;
      done_reg <= done_next;
      icyc_reg <= icyc_next;
      unk_reg <= unk_next;
    end
  end

  // outputs straight from flops
  assign code_addr = pc_reg;
  assign acc_value = acc_reg;
  assign b_value = b_reg;
  assign program_status_word = sw_reg;
  assign data_pointer_register = dpr_reg;
  assign instr_done = done_reg;
  assign instr_cycles = icyc_reg;
  assign unsupported_op = unk_reg;
endmodule // pcit_core
`default_nettype wire

//--- pcit_consts.svh
// constants for the pipelined core instruction timing block
// Contract
// - standard opcodes, modes and status flags
// - sequence purely in system clock cycles
// - most instructions: one byte per clock
// - untaken conditional branch one clock shorter, two with slow flash
// - at most eight clocks; divide 8, multiply 4
// - 109 instructions in fixed duration classes; the core decodes a subset, the rest retire in one clock flagged unsupported
// - indirect add, addc, subb take two clocks
// - working register against accumulator: one clock
// - logic immediate into direct byte: three clocks
// - data pointer increment: one clock, carry
// - system clock 0 to 50 MHz
// - flash read timing stretches some instructions
`ifndef PCIT_CONSTS_SVH
`define PCIT_CONSTS_SVH

// clock figures
`define PCIT_CLK_PERIOD_NS 50
`define PCIT_CLK_MAX_MHZ 50

// reset values
`define PCIT_PC_RST 16'h0000
`define PCIT_BYTE_RST 8'h00
`define PCIT_WORD_RST 16'h0000
`define PCIT_CNT_RST 4'h0

// status word bit positions
`define PCIT_SW_CY 7
`define PCIT_SW_AC 6
`define PCIT_SW_RS1 4
`define PCIT_SW_RS0 3
`define PCIT_SW_OV 2
`define PCIT_SW_P 0

// special function register direct addresses
`define PCIT_SFR_BASE 8'h80
`define PCIT_SFR_ACC 8'he0
`define PCIT_SFR_B 8'hf0
`define PCIT_SFR_SW 8'hd0
`define PCIT_SFR_DPL 8'h82
`define PCIT_SFR_DPH 8'h83

// whole opcodes
`define PCIT_OP_NOP 8'h00
`define PCIT_OP_LJMP 8'h02
`define PCIT_OP_JC 8'h40
`define PCIT_OP_JNC 8'h50
`define PCIT_OP_JZ 8'h60
`define PCIT_OP_JNZ 8'h70
`define PCIT_OP_SJMP 8'h80
`define PCIT_OP_DIV 8'h84
`define PCIT_OP_INCDP 8'ha3
`define PCIT_OP_MUL 8'ha4
`define PCIT_OP_MOVAI 8'h74
`define PCIT_OP_CLRA 8'he4
`define PCIT_OP_CPLA 8'hf4

// high nibbles of operation groups
`define PCIT_HI_INC 4'h0
`define PCIT_HI_DEC 4'h1
`define PCIT_HI_ADD 4'h2
`define PCIT_HI_ADDC 4'h3
`define PCIT_HI_ORL 4'h4
`define PCIT_HI_ANL 4'h5
`define PCIT_HI_XRL 4'h6
`define PCIT_HI_SUBB 4'h9

// low nibbles of addressing modes
`define PCIT_LO_DIRA 4'h2
`define PCIT_LO_DIRI 4'h3
`define PCIT_LO_IMM 4'h4
`define PCIT_LO_DIR 4'h5
`define PCIT_LO_IND0 4'h6
`define PCIT_LO_IND1 4'h7
`define PCIT_LO_REG 4'h8

// extra clocks beyond the byte count
`define PCIT_EXTRA_IND 4'h1
`define PCIT_EXTRA_MUL 4'h3
`define PCIT_EXTRA_DIV 4'h7
`define PCIT_EXTRA_TAKEN 4'h1

`endif

//--- pcit_pkg.sv
// types shared by the pipelined core files
`default_nettype none
package pcit_pkg;
  // sequencer states, gray along opcode -> byte1 -> byte2 -> extra
  typedef enum logic [1:0] {
    ST_OP = 2'b00,
    ST_B1 = 2'b01,
    ST_B2 = 2'b11,
    ST_EX = 2'b10
  } pcit_state_e;

  // arithmetic unit operations
  typedef enum logic [3:0] {
    ALU_PASS = 4'h0,
    ALU_ADD = 4'h1,
    ALU_ADDC = 4'h2,
    ALU_SUBB = 4'h3,
    ALU_AND = 4'h4,
    ALU_OR = 4'h5,
    ALU_XOR = 4'h6,
    ALU_INC = 4'h7,
    ALU_DEC = 4'h8
  } pcit_alu_e;
endpackage
`default_nettype wire

//--- pcit_alu.sv
// combinational byte arithmetic and logic unit with carry flags
`timescale 1ns/1ps
`default_nettype none
module pcit_alu (
  input wire pcit_pkg::pcit_alu_e op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cy_in,
  output logic [7:0] res,
  output logic cy,
  output logic ac,
  output logic ov,
  output logic flags_we
);
  import pcit_pkg::*;

  logic c; // carry or borrow actually used
  logic [8:0] wide; // nine bit sum or difference
  logic [4:0] half; // nibble sum for auxiliary carry

  always_comb begin
    c = (op == ALU_ADDC || op == ALU_SUBB) ? cy_in : 1'b0;
    wide = 9'h000;
    half = 5'h00;
    res = a;
    cy = cy_in;
    ac = 1'b0;
    ov = 1'b0;
    flags_we = 1'b0;
    case (op)
      ALU_ADD, ALU_ADDC: begin
        wide = {1'b0, a} + {1'b0, b} + {8'h00, c};
        half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
        res = wide[7:0];
        cy = wide[8];
        ac = half[4];
        // overflow: like signs give an unlike result
        ov = (a[7] == b[7]) && (wide[7] != a[7]);
        flags_we = 1'b1;
      end
      ALU_SUBB: begin
        wide = {1'b0, a} - {1'b0, b} - {8'h00, c};
        half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
        res = wide[7:0];
        cy = wide[8];
        ac = half[4];
        ov = (a[7] != b[7]) && (wide[7] != a[7]);
        flags_we = 1'b1;
      end
      ALU_AND: res = a & b;
      ALU_OR: res = a | b;
      ALU_XOR: res = a ^ b;
      // increment and decrement leave every flag alone
      ALU_INC: res = a + 8'h01;
      ALU_DEC: res = a - 8'h01;
      default: res = a;
    endcase
  end
endmodule // pcit_alu
`default_nettype wire

//--- pcit_core_assertions.sv
// concurrent checks on the ports of the pipelined core
`timescale 1ns/1ps
`default_nettype none
`include "pcit_consts.svh"
module pcit_core_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] code_data,
  input wire logic flash_read_timing_setting,
  input wire logic [15:0] code_addr,
  input wire logic [7:0] acc_value,
  input wire logic [7:0] b_value,
  input wire logic [7:0] program_status_word,
  input wire logic [15:0] data_pointer_register,
  input wire logic instr_done,
  input wire logic [3:0] instr_cycles,
  input wire logic unsupported_op
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  reset_clear_a: assert property (
    disable iff (1'b0) !rst_n |=> code_addr == `PCIT_PC_RST && acc_value == `PCIT_BYTE_RST
      && !instr_done && instr_cycles == `PCIT_CNT_RST)
    else $error("state not cleared after reset");
  cycle_range_a: assert property (
    instr_done |-> instr_cycles >= 4'h1 && instr_cycles <= 4'h8)
    else $error("instruction duration outside one to eight clocks");
  done_gap_a: assert property (
    !instr_done [*8] |=> instr_done)
    else $error("no instruction retired within eight clocks");
  odd_op_a: assert property (
    unsupported_op |-> instr_done && instr_cycles == 4'h1)
    else $error("unknown opcode not retired as one byte one clock");
  parity_flag_a: assert property (
    program_status_word[`PCIT_SW_P] == ^acc_value)
    else $error("parity flag disagrees with accumulator");
  acc_retire_a: assert property (
    $changed(acc_value) |-> instr_done)
    else $error("accumulator changed outside retirement");
  // b register changes, from multiply, divide or a direct write, only at retirement
  b_retire_a: assert property (
    $changed(b_value) |-> instr_done)
    else $error("b register changed outside retirement");
  data_pointer_register_retire_a: assert property (
    $changed(data_pointer_register) |-> instr_done)
    else $error("data pointer changed outside retirement");
  count_hold_a: assert property (
    !instr_done |-> $stable(instr_cycles))
    else $error("clock count moved without retirement");
  // one byte per clock inside an instruction
  fetch_step_a: assert property (
    $changed(code_addr) && !instr_done |-> code_addr == $past(code_addr) + 16'h0001)
    else $error("fetch address jumped inside an instruction");
  // unknown opcode has no side effect
  odd_op_quiet_a: assert property (
    unsupported_op |-> $stable(acc_value) && $stable(b_value) && $stable(program_status_word)
      && $stable(data_pointer_register))
    else $error("unknown opcode changed architectural state");
  // five clocks only with slow flash
  slow_jump_a: assert property (
    instr_done && instr_cycles == 4'h5 |-> flash_read_timing_setting)
    else $error("five clock instruction seen with fast flash timing");
endmodule // pcit_core_checker

bind pcit_core pcit_core_checker pcit_core_checker_i (
  .clk(clk),
  .rst_n(rst_n),
  .code_data(code_data),
  .flash_read_timing_setting(flash_read_timing_setting),
  .code_addr(code_addr),
  .acc_value(acc_value),
  .b_value(b_value),
  .program_status_word(program_status_word),
  .data_pointer_register(data_pointer_register),
  .instr_done(instr_done),
  .instr_cycles(instr_cycles),
  .unsupported_op(unsupported_op)
);
`default_nettype wire

//--- pcit_flash_model.sv
// behavioural program memory read in the same cycle as the fetch address
`timescale 1ns/1ps
`default_nettype none
module pcit_flash_model (
  input wire logic clk,
  input wire logic [15:0] code_addr,
  output logic [7:0] code_data,
  input wire logic load_we,
  input wire logic [7:0] load_addr,
  input wire logic [7:0] load_byte
);
  logic [7:0] mem [0:255]; // program image, 256 bytes only

  // image loading, done while the core is held in reset
  always_ff @(posedge clk) begin
    if (load_we) begin
      mem[load_addr] <= load_byte;
    end
  end

  // combinational read; beyond the image a changing pattern, never a stale byte
  always_comb begin
    if (code_addr[15:8] == 8'h00) begin
      code_data = mem[code_addr[7:0]];
    end else begin
      code_data = ~code_addr[7:0];
    end
  end
endmodule // pcit_flash_model
`default_nettype wire

//--- tb_pipelined_core_instruction_timing.sv
// self-checking testbench for the pipelined core instruction timing
`timescale 1ns/1ps
`default_nettype none
`include "pcit_consts.svh"
module tb_pipelined_core_instruction_timing;
  logic clk, rst_n, slow, load_we; // bench-driven inputs
  logic [7:0] load_addr, load_byte, code_data;
  logic [15:0] code_addr, data_pointer_register;
  logic [7:0] acc_value, b_value, program_status_word;
  logic instr_done, unsupported_op;
  logic [3:0] instr_cycles;
  logic [7:0] img [0:255]; // program image built per test
  int failures, checks;

  pcit_core pcit_core_i (.clk(clk), .rst_n(rst_n), .code_data(code_data),
    .flash_read_timing_setting(slow), .code_addr(code_addr), .acc_value(acc_value),
    .b_value(b_value), .program_status_word(program_status_word),
    .data_pointer_register(data_pointer_register), .instr_done(instr_done),
    .instr_cycles(instr_cycles), .unsupported_op(unsupported_op));
  pcit_flash_model pcit_flash_model_i (.clk(clk), .code_addr(code_addr), .code_data(code_data),
    .load_we(load_we), .load_addr(load_addr), .load_byte(load_byte));

  initial clk = 1'b0;
  always #(`PCIT_CLK_PERIOD_NS / 2) clk = ~clk;

  // compare helpers, one for each width of result
  task automatic check_byte(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s at %0t: got %h expected %h", what, $time, got, exp);
    end
  endtask
  task automatic check_word(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s at %0t: got %h expected %h", what, $time, got, exp);
    end
  endtask
  task automatic check_count(input string what, input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s at %0t: got %h expected %h", what, $time, got, exp);
    end
  endtask

  // writes bytes into the image from a start address
  task automatic put(input logic [7:0] a, input logic [7:0] q[$]);
    foreach (q[i]) img[a + 8'(i)] = q[i];
  endtask

  // reloads memory under reset, runs and checks every instruction's clock count
  task automatic run_prog(input logic s, input logic [3:0] exp[$]);
    int k;
    rst_n = 1'b0;
    slow = s;
    for (k = 0; k < 256; k++) begin
      load_we = 1'b1;
      load_addr = k[7:0];
      load_byte = img[k];
      @(negedge clk);
    end
    load_we = 1'b0;
    check_word("fetch address in reset", code_addr, `PCIT_PC_RST);
    check_byte("accumulator in reset", acc_value, `PCIT_BYTE_RST);
    rst_n = 1'b1;
    @(negedge clk);
    foreach (exp[i]) begin
      // an instruction never needs more than eight clocks, so twelve is ample
      for (k = 0; k < 12 && instr_done !== 1'b1; k++) @(negedge clk);
      check_count("instruction clocks", instr_cycles, exp[i]);
      if (i < exp.size() - 1) @(negedge clk);
    end
  endtask

  // register, direct, immediate and indirect arithmetic forms
  task automatic t_arith();
    foreach (img[i]) img[i] = 8'h00;
    // data memory is not reset, so r0 and the indirect byte are set up first
    put(8'h00, {8'h53, 8'h00, 8'h00, 8'h43, 8'h00, 8'h10, 8'h53, 8'h10, 8'h00, 8'h43, 8'h10, 8'h22,
      8'h74, 8'h05, 8'h28, 8'h24, 8'h03, 8'h26, 8'h35, 8'he0});
    run_prog(1'b0, {4'h3, 4'h3, 4'h3, 4'h3, 4'h2, 4'h1, 4'h2, 4'h2, 4'h2});
    check_byte("accumulator", acc_value, 8'h74);
    check_byte("status word", program_status_word, 8'h40);
    check_word("fetch address", code_addr, 16'h0014);
    $display("test arith done");
  endtask

  // logic forms, pointer carry, multiply, divide and an unknown opcode
  task automatic t_logic_muldiv();
    foreach (img[i]) img[i] = 8'h00;
    put(8'h00, {8'h74, 8'hf0, 8'h54, 8'h3c, 8'h44, 8'h05, 8'h64, 8'hff, 8'h94, 8'h0a,
      8'h43, 8'h82, 8'hff, 8'ha3, 8'h43, 8'hf0, 8'h03, 8'ha4, 8'h84, 8'ha5});
    run_prog(1'b0, {4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h1, 4'h3, 4'h4, 4'h8, 4'h1});
    check_count("unknown opcode flag", {3'b000, unsupported_op}, 4'h1);
    check_byte("accumulator", acc_value, 8'h20);
    check_byte("b register", b_value, 8'h00);
    check_word("data pointer", data_pointer_register, 16'h0100);
    check_byte("status word", program_status_word, 8'h01);
    check_word("fetch address", code_addr, 16'h0014);
    $display("test logic_muldiv done");
  endtask

  // increment and decrement forms, accumulator into a direct byte, indirect subtract
  task automatic t_incdec();
    foreach (img[i]) img[i] = 8'h00;
    put(8'h00, {8'h74, 8'h30, 8'h53, 8'h01, 8'h00, 8'h62, 8'h01, 8'h53, 8'h30, 8'h00, 8'h07, 8'h07,
      8'h15, 8'h30, 8'h09, 8'h19, 8'h14, 8'h97, 8'h05, 8'he0});
    run_prog(1'b0, {4'h2, 4'h3, 4'h2, 4'h3, 4'h2, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2});
    check_byte("accumulator", acc_value, 8'h2f);
    check_byte("status word", program_status_word, 8'h01);
    check_word("fetch address", code_addr, 16'h0014);
    $display("test incdec done");
  endtask

  // JZ taken and not taken, JNZ and JC not taken, JNC, SJMP and LJMP taken, at either flash timing
  task automatic t_branch(input logic s);
    logic [3:0] x;
    x = {3'b000, s};
    foreach (img[i]) img[i] = 8'h00;
    put(8'h00, {8'he4, 8'h70, 8'h05, 8'h40, 8'h05, 8'h60, 8'h02, 8'h00, 8'h00, 8'h50, 8'h01,
      8'h00, 8'hf4, 8'h60, 8'h10, 8'h02, 8'h00, 8'h20});
    put(8'h20, {8'h80, 8'hfe});
    // slow flash adds a clock to taken branches only
    run_prog(s, {4'h1, 4'h2, 4'h2, 4'h3 + x, 4'h3 + x, 4'h1, 4'h2, 4'h4 + x, 4'h3 + x});
    check_word("branch target", code_addr, 16'h0020);
    check_byte("accumulator", acc_value, 8'hff);
    $display("test branch done");
  endtask

  // counts and verdict, the single end of the run
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog sized well above the five tests, about 1400 clocks
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    $display("watchdog expired at %0t", $time);
    report_and_stop();
  end

  // main sequence
  initial begin
    failures = 0;
    checks = 0;
    rst_n = 1'b0;
    slow = 1'b0;
    load_we = 1'b0;
    load_addr = 8'h00;
    load_byte = 8'h00;
    repeat (8) @(negedge clk);
    t_arith();
    t_logic_muldiv();
    t_incdec();
    t_branch(1'b0);
    t_branch(1'b1);
    report_and_stop();
  end
endmodule // tb_pipelined_core_instruction_timing
`default_nettype wire
